//--- design/pcgl_pkg.sv
package pcgl_pkg;

	localparam int NUM_PORTS = 4;
	localparam int NUM_PINS  = 8;
	localparam int CNT_W     = 24;

	// Register offsets (word index on the plain port)
	localparam logic [3:0] ADDR_GLOBAL  = 4'h0;
	localparam logic [3:0] ADDR_PINMODE = 4'h1;
	localparam logic [3:0] ADDR_PORT0   = 4'h4;
	localparam logic [3:0] ADDR_HOLD0   = 4'h8;
	localparam logic [3:0] ADDR_STATUS  = 4'hC;

	// Pin mode codes
	localparam logic [1:0] PM_INPUT = 2'h0;
	localparam logic [1:0] PM_ALARM = 2'h1;
	localparam logic [1:0] PM_LOW   = 2'h2;
	localparam logic [1:0] PM_HIGH  = 2'h3;

	// Global update sources
	localparam logic [1:0] GS_PORT = 2'h0;
	localparam logic [1:0] GS_GLOB = 2'h1;
	localparam logic [1:0] GS_ONE  = 2'h2;
	localparam logic [1:0] GS_PIN  = 2'h3;

	// Global signal pin positions
	localparam int PIN_REFO = 1;
	localparam int PIN_REFI = 3;
	localparam int PIN_TRIG = 5;
	localparam int PIN_UPD  = 7;

	typedef struct packed {
		logic los;
		logic oof;
		logic lof;
		logic ais;
		logic rai;
		logic idle;
	} pcgl_alarm_s;

	typedef struct packed {
		logic analog_loop;
		logic line_loop;
		logic payload_loop;
		logic diagnostic_loop;
	} pcgl_loop_s;

	typedef struct packed {
		logic rx_clk;
		logic rx_pos;
		logic rx_neg;
	} pcgl_rxline_s;

endpackage

//--- design/pcgl_port_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// - Two pins per port, each able to show one or more alarms.
// - One pin per port may carry a global signal; disabled ports' pins work.
// - Disabled port with alarm pin mode drives its pin low.
// - Reference, trigger and update use internal sources unless the pin is selected.
// - Pin mode 00 input, 01 alarm, 10 drive low, 11 drive high.
// - Four-bit alarm selector picks single or grouped alarm conditions.
// - Error counters saturate at maximum instead of wrapping.
// - Live nonzero bit, latched first-count bit, latched per-event bit.
// - Update copies each counter to its hold register and clears it.
// - Event coincident with clear loads the counter with one.
// - Update request from one-second, pin, port bit or global bit.
// - Done follows hardware update high and low shortly after.
// - Ports not on global update are masked from global done.
// - Error source select chooses local bits or port/global/pin trigger.
// - Three-bit loopback field decodes to analog, line, payload, diagnostic.
// - Analog loopback suppressed while loop-timed mode is set.
// - Analog loopback with line interface off routes tx clock/data to rx.
// - Line loopback sends rx clock out, resamples rx data on it.
// - Optional rx AIS in line loop; no AIS sent with line plus diag.
// - Payload loop reframes rx payload, ignores tx frame start input.
// - Payload loop may force tx data enable and frame start low.
// - Diagnostic loop returns pre-encoding tx data to receive path.
module pcgl_port_ctrl
	import pcgl_pkg::*;
#(
	parameter int PORTS = NUM_PORTS,
	parameter int CW    = CNT_W
) (
	input  wire logic                  clock,            // System clock
	input  wire logic                  rst,              // Sync reset
	input  wire logic [3:0]            addr,             // Register index
	input  wire logic [31:0]           wdata,            // Write data
	input  wire logic                  wr,               // Write strobe
	input  wire logic                  rd,               // Read strobe
	output logic [31:0]                rdata,            // Read data
	input  wire logic [7:0]            pin_in,           // Pin levels
	output logic [7:0]                 pin_out,          // Pin drive
	output logic [7:0]                 pin_oe,           // Pin enable
	input  wire pcgl_alarm_s [3:0]     alarms,           // Per-port alarms
	input  wire logic [3:0]            err_event,        // Count events
	input  wire logic                  one_second,       // 1 s reference
	input  wire logic                  ref8k_core,       // Internal 8 kHz
	output logic                       ref8k_input,      // 8 kHz to core
	output logic [3:0]                 manual_error_trigger, // Insert
	output logic [3:0]                 counter_update_done,  // Per port
	output logic                       global_done,      // Global done
	output pcgl_loop_s [3:0]           loop_mode,        // Decoded loops
	input  wire pcgl_rxline_s [3:0]    rx_line,          // Rx pins
	input  wire logic [3:0]            tx_line_clock,    // Tx clocks
	input  wire logic [3:0]            tx_positive_data, // Tx pos
	input  wire logic [3:0]            tx_negative_data, // Tx neg
	input  wire logic [3:0]            tx_frame_start_in, // Tx SOF in
	input  wire logic [3:0]            tx_den_core,      // Framer enable
	input  wire logic [3:0]            tx_sof_core,      // Framer SOF
	output pcgl_rxline_s [3:0]         rx_to_core,       // Rx to decoder
	output logic [3:0]                 tx_clock_out,     // Tx clock out
	output logic [3:0]                 tx_pos_out,       // Tx pos out
	output logic [3:0]                 tx_neg_out,       // Tx neg out
	output logic [3:0]                 tx_frame_start_out, // Tx SOF out
	output logic [3:0]                 tx_data_enable_out, // Tx DEN out
	output logic [3:0]                 rx_ais_force,     // Rx AIS on
	output logic [3:0]                 tx_ais_block,     // Suppress AIS
	output logic [3:0]                 sof_ignore        // Drop SOF in
);

////////////////////////////////////////////////////////////////////////
	// Global reg: [1:0] update source, [2] global update bit,
	// [3] global trigger, [4] ref out en, [5] ref in sel,
	// [6] pin trigger sel, [7] hw update uses pin.
	// Port reg: [2:0] loop, [3] loop timed, [4] enable, [5] uses global,
	// [6] update bit, [7] trigger bit, [8] src select, [9] local trigger,
	// [10] rx AIS option, [11] PAYLOAD_LOOP output kill, [12] LINE_INTERFACE_UNIT enable,
	// [15:13] spare, [19:16] alarm sel A, [23:20] alarm sel B.
	typedef struct packed {
		logic [7:0]             glob;
		logic [15:0]            pinmode;
		logic [3:0][23:0]       port;
		logic [3:0][CW-1:0]     cnt;
		logic [3:0][CW-1:0]     hold;
		logic [3:0]             live;
		logic [3:0]             first_l;
		logic [3:0]             event_l;
		logic [3:0]             upd_q;
		logic [7:0]             pin_s1;
		logic [7:0]             pin_s2;
		logic [31:0]            rdata;
		logic [7:0]             pout;
		logic [7:0]             poe;
		logic                   refi;
		logic [3:0]             trig;
		logic [3:0]             done;
		logic                   gdone;
		pcgl_loop_s [3:0]       loop;
		pcgl_rxline_s [3:0]     rxc;
		logic [3:0]             rx_d1;
		logic [3:0]             llb_pos;
		logic [3:0]             llb_neg;
		logic [3:0]             tclk;
		logic [3:0]             tpos;
		logic [3:0]             tneg;
		logic [3:0]             tsof;
		logic [3:0]             tden;
		logic [3:0]             rais;
		logic [3:0]             aisb;
		logic [3:0]             sofi;
	} pcgl_state_s;

	pcgl_state_s st_ff;
	pcgl_state_s nxt_st;

	localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
	localparam logic [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

	function automatic logic alarm_pick(logic [3:0] sel, pcgl_alarm_s a);
		logic r;
		r = 1'b0;
		case (sel)
			4'h0: r = a.los;
			4'h1: r = a.oof;
			4'h2: r = a.lof;
			4'h3: r = a.ais;
			4'h4: r = a.rai;
			4'h5: r = a.idle;
			4'hB, 4'hD: r = a.los | a.lof | a.ais;
			4'hE: r = a.rai | a.idle;
			4'hF: r = |a;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [23:0] pr;
		logic [1:0]  pm;
		logic        hw_upd;
		logic        glob_sig;
		logic        upd;
		logic        trig_ext;
		logic [3:0]  pin_idx;
		pr       = '0;
		pm       = '0;
		hw_upd   = 1'b0;
		glob_sig = 1'b0;
		upd      = 1'b0;
		trig_ext = 1'b0;
		pin_idx  = '0;
		nxt_st   = st_ff;

		// Pins pass two flops before use
		nxt_st.pin_s1 = pin_in;
		nxt_st.pin_s2 = st_ff.pin_s1;

		// Register writes
		if (wr) begin
			if (addr == ADDR_GLOBAL)
				nxt_st.glob = wdata[7:0];
			if (addr == ADDR_PINMODE)
				nxt_st.pinmode = wdata[15:0];
			for (int p = 0; p < PORTS; p++)
				if (addr == ADDR_PORT0 + 4'(p))
					nxt_st.port[p] = wdata[23:0];
		end

		// Unselected pin sources fall back to ref8k_core, the global trigger bit and one_second
		nxt_st.refi = st_ff.glob[5] ? st_ff.pin_s2[PIN_REFI] : ref8k_core;
		trig_ext = st_ff.glob[6] ? st_ff.pin_s2[PIN_TRIG]
					: st_ff.glob[3];
		hw_upd = st_ff.glob[7] ? st_ff.pin_s2[PIN_UPD] : one_second;

		glob_sig = 1'b0;
		case (st_ff.glob[1:0])
			GS_GLOB: glob_sig = st_ff.glob[2];
			GS_ONE:  glob_sig = hw_upd;
			GS_PIN:  glob_sig = hw_upd;
			default: glob_sig = 1'b0;
		endcase

		nxt_st.gdone = 1'b0;
		for (int p = 0; p < PORTS; p++) begin
			pr = st_ff.port[p];
			// Port update: own bit or shared global source
			upd = pr[5] ? glob_sig : pr[6];
			nxt_st.upd_q[p] = upd;
			// Done tracks the level one cycle later, high and low
			nxt_st.done[p] = upd;
			if (pr[5] && upd)
				nxt_st.gdone = 1'b1;
			// Error insertion source
			nxt_st.trig[p] = pr[8] ? (pr[7] | trig_ext) : pr[9];

			// Counter: update on rising request edge
			if (upd && !st_ff.upd_q[p]) begin
				nxt_st.hold[p] = st_ff.cnt[p];
				nxt_st.cnt[p]  = err_event[p] ? CNT_ONE : '0;
			end else if (err_event[p] && st_ff.cnt[p] != CNT_MAX) begin
				nxt_st.cnt[p] = st_ff.cnt[p] + CNT_ONE;
			end
			nxt_st.live[p] = (nxt_st.cnt[p] != '0);
			if (err_event[p])
				nxt_st.event_l[p] = 1'b1;
			if (!st_ff.live[p] && nxt_st.live[p])
				nxt_st.first_l[p] = 1'b1;

			// Loopback decode, registered for clean switching
			nxt_st.loop[p] = '0;
			case (pr[2:0])
				3'h1: nxt_st.loop[p].analog_loop = !pr[3];
				3'h2: nxt_st.loop[p].line_loop = 1'b1;
				3'h3: nxt_st.loop[p].payload_loop = 1'b1;
				3'h6: begin
					nxt_st.loop[p].line_loop       = 1'b1;
					nxt_st.loop[p].diagnostic_loop = 1'b1;
				end
				3'h4, 3'h5, 3'h7: nxt_st.loop[p].diagnostic_loop = 1'b1;
				default: nxt_st.loop[p] = '0;
			endcase

			// Line loop resamples rx data on the rx clock rising edge
			nxt_st.rx_d1[p] = rx_line[p].rx_clk;
			if (rx_line[p].rx_clk && !st_ff.rx_d1[p]) begin
				nxt_st.llb_pos[p] = rx_line[p].rx_pos;
				nxt_st.llb_neg[p] = rx_line[p].rx_neg;
			end
			nxt_st.rxc[p] = rx_line[p];
			nxt_st.tclk[p] = tx_line_clock[p];
			nxt_st.tpos[p] = tx_positive_data[p];
			nxt_st.tneg[p] = tx_negative_data[p];
			if (st_ff.loop[p].analog_loop && !pr[12]) begin
				nxt_st.rxc[p].rx_clk = tx_line_clock[p];
				nxt_st.rxc[p].rx_pos = tx_positive_data[p];
				nxt_st.rxc[p].rx_neg = tx_negative_data[p];
			end
			if (st_ff.loop[p].line_loop) begin
				nxt_st.tclk[p] = rx_line[p].rx_clk;
				nxt_st.tpos[p] = st_ff.llb_pos[p];
				nxt_st.tneg[p] = st_ff.llb_neg[p];
			end
			nxt_st.rais[p] = pr[10] && (st_ff.loop[p].line_loop
					|| st_ff.loop[p].payload_loop);
			nxt_st.aisb[p] = st_ff.loop[p].line_loop
					&& st_ff.loop[p].diagnostic_loop;
			nxt_st.sofi[p] = st_ff.loop[p].payload_loop;
			nxt_st.tsof[p] = st_ff.loop[p].payload_loop ? tx_sof_core[p]
					: tx_frame_start_in[p];
			nxt_st.tden[p] = tx_den_core[p];
			if (st_ff.loop[p].payload_loop && pr[11]) begin
				nxt_st.tsof[p] = 1'b0;
				nxt_st.tden[p] = 1'b0;
			end
		end

		// Pins: two per port, index 2p is A and 2p+1 is B
		for (int i = 0; i < NUM_PINS; i++) begin
			pr = st_ff.port[i / 2];
			pm = st_ff.pinmode[2*i +: 2];
			nxt_st.poe[i]  = 1'b0;
			nxt_st.pout[i] = 1'b0;
			case (pm)
				PM_ALARM: begin
					nxt_st.poe[i] = 1'b1;
					// Disabled port drives low
					nxt_st.pout[i] = pr[4] && alarm_pick(
						(i % 2 == 0) ? pr[19:16] : pr[23:20],
						alarms[i / 2]);
				end
				PM_LOW: nxt_st.poe[i] = 1'b1;
				PM_HIGH: begin
					nxt_st.poe[i]  = 1'b1;
					nxt_st.pout[i] = 1'b1;
				end
				default: nxt_st.poe[i] = 1'b0;
			endcase
		end
		// Global pins override the mode code, enabled or not
		if (st_ff.glob[4]) begin
			nxt_st.poe[PIN_REFO]  = 1'b1;
			nxt_st.pout[PIN_REFO] = ref8k_core;
		end
		if (st_ff.glob[5])
			nxt_st.poe[PIN_REFI] = 1'b0;
		if (st_ff.glob[6])
			nxt_st.poe[PIN_TRIG] = 1'b0;
		if (st_ff.glob[7])
			nxt_st.poe[PIN_UPD] = 1'b0;

		// Read path, data one cycle after strobe
		nxt_st.rdata = '0;
		if (rd) begin
			if (addr == ADDR_GLOBAL)
				nxt_st.rdata = {24'h000000, st_ff.glob};
			if (addr == ADDR_PINMODE)
				nxt_st.rdata = {16'h0000, st_ff.pinmode};
			if (addr == ADDR_STATUS)
				nxt_st.rdata = {15'h0000, st_ff.gdone, st_ff.done,
					st_ff.event_l, st_ff.first_l, st_ff.live};
			for (int p = 0; p < PORTS; p++) begin
				if (addr == ADDR_PORT0 + 4'(p))
					nxt_st.rdata = {8'h00, st_ff.port[p]};
				if (addr == ADDR_HOLD0 + 4'(p))
					nxt_st.rdata = 32'(st_ff.hold[p]);
			end
			// Reading status clears latched bits; new events win
			if (addr == ADDR_STATUS) begin
				nxt_st.event_l = err_event;
				nxt_st.first_l = ~st_ff.live & nxt_st.live;
			end
		end
	end

////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock) begin
		if (rst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign rdata                = st_ff.rdata;
	assign pin_out              = st_ff.pout;
	assign pin_oe               = st_ff.poe;
	assign ref8k_input          = st_ff.refi;
	assign manual_error_trigger = st_ff.trig;
	assign counter_update_done  = st_ff.done;
	assign global_done          = st_ff.gdone;
	assign loop_mode            = st_ff.loop;
	assign rx_to_core           = st_ff.rxc;
	assign tx_clock_out         = st_ff.tclk;
	assign tx_pos_out           = st_ff.tpos;
	assign tx_neg_out           = st_ff.tneg;
	assign tx_frame_start_out   = st_ff.tsof;
	assign tx_data_enable_out   = st_ff.tden;
	assign rx_ais_force         = st_ff.rais;
	assign tx_ais_block         = st_ff.aisb;
	assign sof_ignore           = st_ff.sofi;

endmodule

//--- testbench/pcgl_port_ctrl_monitor.sv
`timescale 1ns/100ps
module pcgl_port_ctrl_monitor
	import pcgl_pkg::*;
#(parameter int PORTS = NUM_PORTS, parameter int CW = CNT_W) (
	input wire logic               clock,                // Clock
	input wire logic               rst,                  // Reset
	input wire logic [3:0]         addr,                 // Index
	input wire logic [31:0]        wdata,                // Data
	input wire logic               wr,                   // Write
	input wire logic [7:0]         pin_out,              // Pin drive
	input wire logic [7:0]         pin_oe,               // Pin enable
	input wire logic [3:0]         manual_error_trigger, // Insert
	input wire pcgl_loop_s [3:0]   loop_mode,            // Loops
	input wire pcgl_rxline_s [3:0] rx_line,              // Rx pins
	input wire logic [3:0]         tx_line_clock,        // Tx clock
	input wire logic [3:0]         tx_positive_data,     // Tx pos
	input wire logic [3:0]         tx_negative_data,     // Tx neg
	input wire pcgl_rxline_s [3:0] rx_to_core,           // Rx core
	input wire logic [3:0]         tx_clock_out,         // Tx clk out
	input wire logic [3:0]         tx_data_enable_out,   // Tx DEN
	input wire logic [3:0]         tx_frame_start_out,   // Tx SOF
	input wire logic [3:0]         tx_frame_start_in,    // Tx SOF pin
	input wire logic [3:0]         tx_pos_out,           // Tx pos out
	input wire logic [3:0]         tx_neg_out,           // Tx neg out
	input wire logic [3:0]         rx_ais_force,         // Rx AIS
	input wire logic [3:0]         tx_ais_block,         // AIS block
	input wire logic [3:0]         sof_ignore            // SOF drop
);
	logic [7:0]  g_ff;
	logic [15:0] pm_ff;
	logic [12:0] pr_ff [4];
	logic [1:0]  q_ff;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Shadow config; judged only after three quiet cycles
	always_ff @(posedge clock) begin
		if (rst) begin
			g_ff <= 8'h0;
			pm_ff <= 16'h0;
			pr_ff <= '{default: 13'h0};
			q_ff <= 2'h0;
		end else begin
			if (wr && addr == ADDR_GLOBAL)
				g_ff <= wdata[7:0];
			if (wr && addr == ADDR_PINMODE)
				pm_ff <= wdata[15:0];
			if (wr && addr[3:2] == 2'h1)
				pr_ff[addr[1:0]] <= wdata[12:0];
			q_ff <= wr ? 2'h0 : (q_ff == 2'h3 ? q_ff : q_ff + 2'h1);
		end
	end
	sequence s_set;
		q_ff == 2'h3;
	endsequence
	////////////////////////////////////////////////////////////////////////
	for (genvar p = 0; p < 4; p++) begin : g_port
		logic [2:0] c;
		assign c = pr_ff[p][2:0];
		property p_loop;
			s_set |-> loop_mode[p] == {c == 3'h1 && !pr_ff[p][3],
				c == 3'h2 || c == 3'h6, c == 3'h3, c[2]};
		endproperty
		a_loop: assert property (p_loop)
			else $error("loop decode wrong");
		property p_trig;
			s_set ##0 !g_ff[6] |-> manual_error_trigger[p] ==
				(pr_ff[p][8] ? pr_ff[p][7] | g_ff[3] : pr_ff[p][9]);
		endproperty
		a_trig: assert property (p_trig)
			else $error("trigger source wrong");
		property p_kill;
			s_set ##0 loop_mode[p].payload_loop && pr_ff[p][11] |->
				!tx_data_enable_out[p] && !tx_frame_start_out[p];
		endproperty
		a_kill: assert property (p_kill)
			else $error("payload loop outputs not forced low");
		property p_alb;
			s_set ##0 loop_mode[p].analog_loop && !pr_ff[p][12] |->
				rx_to_core[p] == {$past(tx_line_clock[p]),
				$past(tx_positive_data[p]), $past(tx_negative_data[p])};
		endproperty
		a_alb: assert property (p_alb)
			else $error("analog loop path wrong");
		property p_llb;
			s_set ##0 loop_mode[p].line_loop |->
				tx_clock_out[p] == $past(rx_line[p].rx_clk);
		endproperty
		a_llb: assert property (p_llb)
			else $error("line loop clock wrong");
		property p_ais;
			s_set |-> rx_ais_force[p] == (pr_ff[p][10] &&
				(c == 3'h2 || c == 3'h3 || c == 3'h6)) &&
				tx_ais_block[p] == (c == 3'h6) &&
				sof_ignore[p] == (c == 3'h3);
		endproperty
		a_ais: assert property (p_ais)
			else $error("loop AIS or frame start control wrong");
		// Outside line and payload loops the transmit pins follow the core
		property p_pass;
			s_set ##0 !loop_mode[p].line_loop &&
				!loop_mode[p].payload_loop |->
				tx_pos_out[p] == $past(tx_positive_data[p]) &&
				tx_neg_out[p] == $past(tx_negative_data[p]) &&
				tx_frame_start_out[p] == $past(tx_frame_start_in[p]);
		endproperty
		a_pass: assert property (p_pass)
			else $error("transmit pass-through wrong");
	end
	for (genvar i = 0; i < 8; i++) begin : g_pin
		logic       cl;
		logic [1:0] md;
		assign cl = (i % 2 == 1) && g_ff[4 + i / 2];
		assign md = pm_ff[2 * i +: 2];
		property p_pfix;
			s_set ##0 !cl && md[1] |-> pin_oe[i] && pin_out[i] == md[0];
		endproperty
		a_pfix: assert property (p_pfix)
			else $error("fixed pin level wrong");
		property p_glob;
			s_set ##0 cl |-> pin_oe[i] == (i == 1);
		endproperty
		a_glob: assert property (p_glob)
			else $error("global pin direction wrong");
		property p_dis;
			s_set ##0 !cl && md == PM_ALARM && !pr_ff[i / 2][4] |->
				pin_oe[i] && !pin_out[i];
		endproperty
		a_dis: assert property (p_dis)
			else $error("disabled port alarm pin not low");
		property p_pin_in;
			s_set ##0 !cl && md == PM_INPUT |-> !pin_oe[i];
		endproperty
		a_pin_in: assert property (p_pin_in)
			else $error("input pin driven");
	end
endmodule

//--- testbench/pcgl_far_model.sv
`timescale 1ns/100ps
module pcgl_far_model
	import pcgl_pkg::*;
(
	input  wire logic          clock,             // Clock
	output pcgl_rxline_s [3:0] rx_line,           // Rx pins
	output logic [3:0]         tx_line_clock,     // Tx clocks
	output logic [3:0]         tx_positive_data,  // Tx pos
	output logic [3:0]         tx_negative_data,  // Tx neg
	output logic [3:0]         tx_frame_start_in, // Tx SOF pin
	output logic [3:0]         tx_den_core,       // Framer DEN
	output logic [3:0]         tx_sof_core        // Framer SOF
);
	// Changes every cycle, so a stale sample cannot match by luck
	logic [35:0] lfsr_ff = 36'h9A3C5E71B;
	always_ff @(posedge clock)
		lfsr_ff <= {lfsr_ff[34:0], lfsr_ff[35] ^ lfsr_ff[24]};
	assign {rx_line, tx_line_clock, tx_positive_data, tx_negative_data,
		tx_frame_start_in, tx_den_core, tx_sof_core} = lfsr_ff;
endmodule

//--- testbench/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin \
	comparisons++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("ERROR t=%0t got=%0h exp=%0h", $time, g, e); \
	end \
end
module testbench import pcgl_pkg::*;;
	logic               clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [3:0]         addr = 4'h0, err_event = 4'h0, s_v;
	logic [31:0]        wdata = 32'h0, rdata, e_v, w_v, pw [4];
	logic [7:0]         pin_in = 8'h0, pin_out, pin_oe, g;
	pcgl_alarm_s [3:0]  alarms = '0;
	logic               one_second = 1'b0, ref8k_core = 1'b0, gdone;
	logic               r8i, rd_p = 1'b0;
	logic [15:0]        pm;
	logic [3:0]         done, tlc, tpd, tnd, tsi, tdc, tsc;
	pcgl_rxline_s [3:0] rxl;
	logic [31:0]        exp_q [$];
	int                 n_fail = 0, comparisons = 0, seed = 7, cyc = 0;
	initial forever #25 clock = ~clock;
	pcgl_port_ctrl #(.CW(4)) i_dut (
		.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .alarms(alarms), .err_event(err_event),
		.one_second(one_second), .ref8k_core(ref8k_core),
		.ref8k_input(r8i), .manual_error_trigger(),
		.counter_update_done(done), .global_done(gdone), .loop_mode(),
		.rx_line(rxl), .tx_line_clock(tlc), .tx_positive_data(tpd),
		.tx_negative_data(tnd), .tx_frame_start_in(tsi),
		.tx_den_core(tdc), .tx_sof_core(tsc), .rx_to_core(),
		.tx_clock_out(), .tx_pos_out(), .tx_neg_out(),
		.tx_frame_start_out(), .tx_data_enable_out(), .rx_ais_force(),
		.tx_ais_block(), .sof_ignore());
	pcgl_far_model i_far (.clock(clock), .rx_line(rxl),
		.tx_line_clock(tlc), .tx_positive_data(tpd),
		.tx_negative_data(tnd), .tx_frame_start_in(tsi),
		.tx_den_core(tdc), .tx_sof_core(tsc));
	////////////////////////////////////////////////////////////////////////
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clock);
		rd <= 1'b0;
	endtask
	task automatic wait_done(input int p, input logic v);
		for (int k = 0; k < 20 && done[p] !== v; k++)
			@(negedge clock);
		`CHK(done[p], v)
	endtask
	function automatic logic pick(input logic [3:0] s, pcgl_alarm_s a);
		case (s)
			4'h0: pick = a.los;
			4'h1: pick = a.oof;
			4'h2: pick = a.lof;
			4'h3: pick = a.ais;
			4'h4: pick = a.rai;
			4'h5: pick = a.idle;
			4'hB, 4'hD: pick = a.los | a.lof | a.ais;
			4'hE: pick = a.rai | a.idle;
			4'hF: pick = |a;
			default: pick = 1'b0;
		endcase
	endfunction
	task automatic summarize();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe
	always @(negedge clock) begin
		if (rd_p) begin
			e_v = exp_q.pop_front();
			`CHK(rdata, e_v)
		end
		rd_p = rd;
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		rd_reg(ADDR_STATUS, 32'h0);
		rd_reg(4'h2, 32'h0);
		wr_reg(4'h3, 32'hFFFFFFFF);
		rd_reg(4'h3, 32'h0);
		for (int n = 0; n < 24; n++) begin
			@(posedge clock);
			g = 8'($random(seed)) & 8'hF8;
			pm = 16'($random(seed));
			pin_in <= 8'($random(seed));
			alarms <= 24'($random(seed));
			ref8k_core <= 1'($random(seed));
			for (int p = 0; p < 4; p++) begin
				pw[p] = 32'($random(seed)) & 32'h00FF1F90;
				wr_reg(4'(ADDR_PORT0 + p), pw[p]);
			end
			wr_reg(ADDR_GLOBAL, {24'h0, g});
			wr_reg(ADDR_PINMODE, {16'h0, pm});
			repeat (5) @(negedge clock);
			`CHK(r8i, g[5] ? pin_in[3] : ref8k_core)
			for (int i = 0; i < 8; i++) begin
				s_v = i % 2 ? pw[i / 2][23:20] : pw[i / 2][19:16];
				if (pm[2 * i +: 2] == PM_ALARM && pw[i / 2][4] &&
						!(i % 2 == 1 && g[4 + i / 2]))
					`CHK(pin_out[i], pick(s_v, alarms[i / 2]))
			end
		end
		for (int v = 0; v < 32; v++) begin
			w_v = 32'h810 | 32'(v % 16) | 32'(v / 16) << 12;
			w_v = w_v | 32'((v / 8) % 2) << 10;
			wr_reg(4'(ADDR_PORT0 + v % 4), w_v);
			repeat (4) @(posedge clock);
		end
		pin_in <= 8'h0;
		wr_reg(ADDR_GLOBAL, 32'h0);
		wr_reg(ADDR_PORT0, 32'h10);
		wr_reg(4'(ADDR_PORT0 + 1), 32'h30);
		// Counter is four bits wide here, so twenty events saturate it
		for (int r = 0; r < 2; r++) begin
			repeat (r ? 3 : 20) begin
				@(posedge clock);
				err_event <= 4'h1;
				@(posedge clock);
				err_event <= 4'h0;
			end
			rd_reg(ADDR_STATUS, 32'h111);
			rd_reg(ADDR_STATUS, 32'h1);
			wr_reg(ADDR_PORT0, 32'h50);
			// Second round: an event lands on the clearing edge
			err_event <= r ? 4'h1 : 4'h0;
			@(posedge clock);
			err_event <= 4'h0;
			wait_done(0, 1'b1);
			`CHK(gdone, 1'b0)
			wr_reg(ADDR_PORT0, 32'h10);
			wait_done(0, 1'b0);
			rd_reg(ADDR_HOLD0, r ? 32'h3 : 32'hF);
			rd_reg(ADDR_STATUS, r ? 32'h101 : 32'h0);
		end
		for (int s = 1; s < 4; s++) begin
			w_v = {24'h0, s == 3, 7'(s)};
			wr_reg(ADDR_GLOBAL, w_v | (s == 1 ? 32'h4 : 32'h0));
			one_second <= s == 2;
			pin_in[7] <= s == 3;
			wait_done(1, 1'b1);
			@(negedge clock);
			`CHK({gdone, done[0]}, 2'b10)
			wr_reg(ADDR_GLOBAL, w_v);
			one_second <= 1'b0;
			pin_in[7] <= 1'b0;
			wait_done(1, 1'b0);
		end
		summarize();
	end
endmodule
bind pcgl_port_ctrl pcgl_port_ctrl_monitor #(.PORTS(PORTS), .CW(CW)) u_mon (
	.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
	.pin_out(pin_out), .pin_oe(pin_oe),
	.manual_error_trigger(manual_error_trigger), .loop_mode(loop_mode),
	.rx_line(rx_line), .tx_line_clock(tx_line_clock),
	.tx_positive_data(tx_positive_data),
	.tx_negative_data(tx_negative_data), .rx_to_core(rx_to_core),
	.tx_clock_out(tx_clock_out), .tx_data_enable_out(tx_data_enable_out),
	.tx_frame_start_out(tx_frame_start_out),
	.tx_frame_start_in(tx_frame_start_in), .tx_pos_out(tx_pos_out),
	.tx_neg_out(tx_neg_out), .rx_ais_force(rx_ais_force),
	.tx_ais_block(tx_ais_block), .sof_ignore(sof_ignore));
